// File: bmmc_pkg.sv
// constants, types and ECC column table for the memory module controller
// assumes a 10 MHz sys_clk and straps that are steady during operation
// Functional notes
// - lower limit from switch or slot; 0-8 legal
// - upper limit is lower plus size, shown
// - setting 88 selects slot position code mode
// - address bits 14-23 select the module
// - bits 14-15 pick one of four blocks
// - bits 0-6 row, bits 7-13 column
// - one lamp lit for the accessed block
// - store 22-bit words, pass 16 data bits
// - address with strobe; one module answers
// - read data driven only while data present
// - data ready asserted once read data on bus
// - read done in 320 ns, plus 40 correcting; here 300 ns plus 100
// - write data latched on data present, acknowledged
// - write done within 200 ns
// - refresh row counter used, then incremented
// - refresh cycle ends with data ready
// - good words pass, single errors corrected, reported
// - double errors and some wider ones raise fatal interrupt
// - only one syndrome means no error
// - all-zero syndrome is the good code
package bmmc_pkg;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_NS  = 100;
  localparam int RD_NS   = 320;
  localparam int CORR_NS = 40;
  localparam int WR_NS   = 200;
  localparam int REF_NS  = 200;
  // longest times round down, never below one cycle
  localparam logic [2:0] RD_CYC   =
    3'((RD_NS / CLK_NS) < 1 ? 1 : RD_NS / CLK_NS);
  localparam logic [2:0] CORR_CYC =
    3'((CORR_NS / CLK_NS) < 1 ? 1 : CORR_NS / CLK_NS);
  localparam logic [2:0] WR_CYC   =
    3'((WR_NS / CLK_NS) < 1 ? 1 : WR_NS / CLK_NS);
  localparam logic [2:0] REF_CYC  =
    3'((REF_NS / CLK_NS) < 1 ? 1 : REF_NS / CLK_NS);
  localparam logic [2:0] CNT_MAX  = 3'h7;

  // ***************************************************
  // placement and reset values
  // ***************************************************
  localparam logic [7:0] POS_MODE     = 8'h88;
  localparam logic [7:0] MAX_SWITCH   = 8'h08;
  localparam logic [9:0] MODULE_UNITS = 10'h004;
  localparam logic [9:0] LIMIT_RST    = 10'h000;
  localparam logic [6:0] ROW_RST      = 7'h00;
  localparam logic [3:0] LAMP_RST     = 4'h0;
  localparam logic [3:0] LAMP_ONE     = 4'h1;

  // ***************************************************
  // ecc: syndrome code of each data bit
  // ***************************************************
  // distinct columns of weight two or more
  localparam logic [4:0] ECC_COL [16] = '{
    5'h03, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
    5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16};

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_ACCESS, ST_RD_CHECK, ST_RD_READY,
    ST_WR_WAIT, ST_WR_ACK, ST_REF_RUN
  } bmmc_state_t;

  typedef struct packed {
    logic        memCycleActive;
    logic        writeDirection;
    logic        addrPresentStrobe;
    logic        dataPresent;
    logic        refreshCmd;
    logic [23:0] addr;
    logic [15:0] wdata;
  } bmmc_bus_req_t;

  typedef struct packed {
    logic [6:0]  rowAddr;
    logic [6:0]  colAddr;
    logic [1:0]  blockSel;
    logic        readEn;
    logic        writeEn;
    logic        refreshEn;
    logic [21:0] wdata;
  } bmmc_arr_cmd_t;

endpackage

// File: bmmc_ecc_gen.sv
// six check bits for one 16-bit data word
// purely combinational, used on write and on read check
`timescale 1ns/10ps
module bmmc_ecc_gen (
  // data word in
  input  wire logic [15:0] data,
  // check bits out
  output logic      [5:0]  check
);

  // ***************************************************
  // parity trees
  // ***************************************************
  always_comb begin
    check = 6'h00;
    for (int i = 0; i < 16; i++) begin
      check[4:0] = check[4:0] ^ ({5{data[i]}} & bmmc_pkg::ECC_COL[i]);
    end
    // overall parity makes the whole 22-bit word even
    check[5] = ^{data, check[4:0]};
  end

endmodule

// File: bmmc_ecc_chk.sv
// syndrome, correction and error class of a stored 22-bit word
// word layout: check bits 21:16, data 15:0
`timescale 1ns/10ps
module bmmc_ecc_chk (
  // stored word
  input  wire logic [21:0] word,
  // result
  output logic      [15:0] dataOut,
  output logic             singleErr,
  output logic             multiErr
);

  logic [5:0]  reCheck;
  logic [4:0]  syn;
  logic        ptot;
  logic        noErr;
  logic [15:0] flip;

  bmmc_ecc_gen genCheck (
    .data  (word[15:0]),
    .check (reCheck)
  );

  assign syn  = reCheck[4:0] ^ word[20:16];
  assign ptot = ^word;

  // ***************************************************
  // correction
  // ***************************************************
  for (genvar i = 0; i < 16; i++) begin : g_flip
    assign flip[i] = ptot && (syn == bmmc_pkg::ECC_COL[i]);
  end

  assign dataOut = word[15:0] ^ flip;
  // all-zero syndrome and even word is good
  assign noErr = (syn == 5'h00) && !ptot;
  // odd word: data bit, one check bit or the overall bit
  assign singleErr = ptot &&
    ((syn == 5'h00) || $onehot(syn) || (|flip));
  assign multiErr = !noErr && !singleErr;

endmodule

// File: bmmc_ctrl.sv
// control of one 64K-word memory module on the 24-bit system bus
// assumes bus inputs synchronous to sys_clk, an external 22-bit array
// whose read data is valid the cycle after its read enable
`timescale 1ns/10ps
module bmmc_ctrl (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // system bus from the requester
  input  wire bmmc_pkg::bmmc_bus_req_t busReq,
  // system bus back to the requester
  output logic                         dataReadyAck,
  output logic                         busDataOe,
  output logic          [15:0]         busDataOut,
  // memory array
  output bmmc_pkg::bmmc_arr_cmd_t      arrCmd,
  input  wire logic     [21:0]         arrRdata,
  // placement straps and panel
  input  wire logic     [7:0]          lowerLimitSwitch,
  input  wire logic     [3:0]          slotPositionCode,
  output logic          [9:0]          nextLowerLimit,
  output logic          [3:0]          blockLamp,
  output logic                         limitIllegal,
  // error reporting
  output logic                         singleErrReport,
  output logic                         fatalErrIrq
);

  bmmc_pkg::bmmc_state_t   st_reg;
  bmmc_pkg::bmmc_state_t   st_next;
  bmmc_pkg::bmmc_arr_cmd_t arr_next;
  logic [9:0]  lower_reg;
  logic [9:0]  upper_reg;
  logic        illegal_reg;
  logic [9:0]  lowerCalc;
  logic        posMode;
  logic        switchOk;
  logic [9:0]  addrUnit;
  logic        hit;
  logic        strobeHit;
  logic        rdStart;
  logic        wrStart;
  logic        refStart;
  logic        refPrev_reg;
  logic [2:0]  cnt_reg;
  logic [2:0]  ackAt_reg;
  logic        timeUp;
  logic        rdAck;
  logic        wrAck;
  logic        refAck;
  logic        abort;
  logic [6:0]  refRow_reg;
  logic [15:0] readData_reg;
  logic [3:0]  lamp_reg;
  logic        single_reg;
  logic        fatal_reg;
  logic [5:0]  wrCheck;
  logic [15:0] chkData;
  logic        chkSingle;
  logic        chkMulti;

  // ***************************************************
  // address limits
  // ***************************************************
  // position code mode, equal sized modules
  assign posMode = lowerLimitSwitch == bmmc_pkg::POS_MODE;
  // only switch settings zero to eight
  assign switchOk = lowerLimitSwitch <= bmmc_pkg::MAX_SWITCH;
  assign lowerCalc = posMode ?
    10'(10'(slotPositionCode) * bmmc_pkg::MODULE_UNITS) :
    10'(lowerLimitSwitch);

  // straps sampled every clock, never under the reset itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lower_reg   <= bmmc_pkg::LIMIT_RST;
      upper_reg   <= bmmc_pkg::LIMIT_RST;
      illegal_reg <= 1'b1;
    end else begin
      lower_reg   <= lowerCalc;
      // upper limit is lower plus own size
      upper_reg   <= 10'(lowerCalc + bmmc_pkg::MODULE_UNITS);
      illegal_reg <= !(posMode || switchOk);
    end
  end

  assign nextLowerLimit = upper_reg;
  assign limitIllegal   = illegal_reg;

  // ***************************************************
  // selection
  // ***************************************************
  assign addrUnit = busReq.addr[23:14];
  // upper address bits against both limits
  assign hit = !illegal_reg && (addrUnit >= lower_reg) &&
               (addrUnit < upper_reg);
  // strobe answered only in own range
  assign strobeHit = busReq.memCycleActive &&
                     busReq.addrPresentStrobe && hit;
  assign rdStart  = (st_reg == bmmc_pkg::ST_IDLE) && strobeHit &&
                    !busReq.writeDirection;
  assign wrStart  = (st_reg == bmmc_pkg::ST_IDLE) && strobeHit &&
                    busReq.writeDirection;
  // refresh edge taken by every idle module, selected or not
  assign refStart = (st_reg == bmmc_pkg::ST_IDLE) &&
                    busReq.refreshCmd && !refPrev_reg;

  // ***************************************************
  // cycle timer
  // ***************************************************
  assign timeUp = cnt_reg >= ackAt_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg   <= 3'h0;
      ackAt_reg <= bmmc_pkg::RD_CYC;
    end else begin
      if (refStart || rdStart || wrStart) begin
        cnt_reg <= 3'h1;
      end else if (cnt_reg != bmmc_pkg::CNT_MAX) begin
        cnt_reg <= 3'(cnt_reg + 3'h1);
      end
      if (refStart) begin
        ackAt_reg <= bmmc_pkg::REF_CYC;
      end else if (rdStart) begin
        // read data ready at the read time
        ackAt_reg <= bmmc_pkg::RD_CYC;
      end else if (wrStart) begin
        // write acknowledged at the write time
        ackAt_reg <= bmmc_pkg::WR_CYC;
      end else if (st_reg == bmmc_pkg::ST_RD_CHECK && chkSingle) begin
        ackAt_reg <= 3'(bmmc_pkg::RD_CYC + bmmc_pkg::CORR_CYC);
      end
    end
  end

  // ***************************************************
  // handshake
  // ***************************************************
  // drive read data only under data present
  assign rdAck  = (st_reg == bmmc_pkg::ST_RD_READY) && timeUp &&
                  busReq.dataPresent;
  // acknowledge after the data was taken
  assign wrAck  = (st_reg == bmmc_pkg::ST_WR_ACK) && timeUp;
  assign refAck = (st_reg == bmmc_pkg::ST_REF_RUN) && timeUp;
  // data ready together with the data
  assign dataReadyAck = rdAck || wrAck || refAck;
  assign busDataOe    = rdAck;
  assign busDataOut   = readData_reg;
  // a dropped memory cycle abandons the access
  assign abort = !busReq.memCycleActive &&
                 (st_reg != bmmc_pkg::ST_IDLE) &&
                 (st_reg != bmmc_pkg::ST_REF_RUN);

  // ***************************************************
  // state machine
  // ***************************************************
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      bmmc_pkg::ST_IDLE: begin
        if (refStart) begin
          st_next = bmmc_pkg::ST_REF_RUN;
        end else if (rdStart) begin
          st_next = bmmc_pkg::ST_RD_ACCESS;
        end else if (wrStart) begin
          st_next = bmmc_pkg::ST_WR_WAIT;
        end
      end
      bmmc_pkg::ST_RD_ACCESS: st_next = bmmc_pkg::ST_RD_CHECK;
      bmmc_pkg::ST_RD_CHECK:  st_next = bmmc_pkg::ST_RD_READY;
      bmmc_pkg::ST_RD_READY: begin
        if (rdAck) begin
          st_next = bmmc_pkg::ST_IDLE;
        end
      end
      bmmc_pkg::ST_WR_WAIT: begin
        if (busReq.dataPresent) begin
          st_next = bmmc_pkg::ST_WR_ACK;
        end
      end
      bmmc_pkg::ST_WR_ACK: begin
        if (wrAck) begin
          st_next = bmmc_pkg::ST_IDLE;
        end
      end
      bmmc_pkg::ST_REF_RUN: begin
        if (refAck) begin
          st_next = bmmc_pkg::ST_IDLE;
        end
      end
      default: st_next = bmmc_pkg::ST_IDLE;
    endcase
    if (abort) begin
      st_next = bmmc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= bmmc_pkg::ST_IDLE;
      refPrev_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      refPrev_reg <= busReq.refreshCmd;
    end
  end

  // ***************************************************
  // array command
  // ***************************************************
  bmmc_ecc_gen wrGen (
    .data  (busReq.wdata),
    .check (wrCheck)
  );

  always_comb begin
    arr_next = arrCmd;
    arr_next.readEn    = rdStart;
    // bus data latched on data present
    arr_next.writeEn   = (st_reg == bmmc_pkg::ST_WR_WAIT) &&
                         busReq.dataPresent && !abort;
    arr_next.refreshEn = refStart ||
      ((st_reg == bmmc_pkg::ST_REF_RUN) && !refAck);
    if (rdStart || wrStart) begin
      // row from bits 0-6, column from 7-13
      arr_next.rowAddr  = busReq.addr[6:0];
      arr_next.colAddr  = busReq.addr[13:7];
      // block from bits 14 and 15
      arr_next.blockSel = busReq.addr[15:14];
    end else if (refStart) begin
      // refresh row comes from the counter
      arr_next.rowAddr  = refRow_reg;
    end
    if (arr_next.writeEn) begin
      // six check bits beside sixteen data bits
      arr_next.wdata = {wrCheck, busReq.wdata};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arrCmd <= '0;
    end else begin
      arrCmd <= arr_next;
    end
  end

  // ***************************************************
  // read path and error report
  // ***************************************************
  bmmc_ecc_chk rdChk (
    .word      (arrRdata),
    .dataOut   (chkData),
    .singleErr (chkSingle),
    .multiErr  (chkMulti)
  );

  // report pulses are one cycle; a cpu side must catch them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      readData_reg <= 16'h0000;
      single_reg   <= 1'b0;
      fatal_reg    <= 1'b0;
    end else begin
      single_reg <= 1'b0;
      fatal_reg  <= 1'b0;
      if (st_reg == bmmc_pkg::ST_RD_CHECK) begin
        // corrected data kept for the bus
        readData_reg <= chkData;
        single_reg   <= chkSingle;
        fatal_reg    <= chkMulti;
      end
    end
  end

  assign singleErrReport = single_reg;
  assign fatalErrIrq     = fatal_reg;

  // ***************************************************
  // block lamps and refresh row
  // ***************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_reg   <= bmmc_pkg::LAMP_RST;
      refRow_reg <= bmmc_pkg::ROW_RST;
    end else begin
      if (rdStart || wrStart) begin
        lamp_reg <= 4'(bmmc_pkg::LAMP_ONE << busReq.addr[15:14]);
      end
      if (refAck) begin
        refRow_reg <= 7'(refRow_reg + 7'h01);
      end
    end
  end

  assign blockLamp = lamp_reg;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic reqHold;
  assign reqHold = busReq.memCycleActive && busReq.dataPresent &&
                   !busReq.refreshCmd;

  sequence s_read_start;
    rdStart ##1 reqHold [*3];
  endsequence

  sequence s_write_start;
    wrStart ##1 reqHold [*2];
  endsequence

  a_read_ack_time: assert property (
    s_read_start |-> (dataReadyAck || ackAt_reg == 3'h4))
    else $error("read not acknowledged at three cycles");

  a_read_not_early: assert property (
    rdAck |-> (cnt_reg >= 3'h3) && busDataOe)
    else $error("read acknowledged too early");

  a_write_ack_time: assert property (
    s_write_start |-> dataReadyAck)
    else $error("write not acknowledged at two cycles");

  a_write_latched: assert property (
    wrAck |-> arrCmd.writeEn &&
      arrCmd.wdata[15:0] == $past(busReq.wdata))
    else $error("write data not latched before ack");

  a_unselected_quiet: assert property (
    (st_reg == bmmc_pkg::ST_IDLE) |-> !dataReadyAck && !busDataOe)
    else $error("idle module answered the bus");

  a_drive_gated: assert property (
    busDataOe |-> busReq.dataPresent && busReq.memCycleActive)
    else $error("data driven without data present");

  a_refresh_row: assert property (
    refStart |=> arrCmd.refreshEn && arrCmd.rowAddr == $past(refRow_reg))
    else $error("refresh row not from counter");

  a_refresh_step: assert property (
    refStart |-> ##2 refAck ##1 refRow_reg == $past(refRow_reg, 3) + 7'h01)
    else $error("refresh not ended or row not stepped");

  a_upper_limit: assert property (
    rst_n |=>
      nextLowerLimit == 10'($past(lowerCalc) + bmmc_pkg::MODULE_UNITS))
    else $error("upper limit not lower plus four");

  a_lamp_block: assert property (
    (rdStart || wrStart) |=> $onehot(blockLamp) &&
      blockLamp[$past(busReq.addr[15:14])])
    else $error("wrong block lamp lit");

  a_row_column: assert property (
    rdStart |=> arrCmd.readEn && arrCmd.rowAddr == $past(busReq.addr[6:0])
      && arrCmd.colAddr == $past(busReq.addr[13:7]))
    else $error("row or column address wrong");

  a_fatal_report: assert property (
    (st_reg == bmmc_pkg::ST_RD_CHECK && chkMulti) |=> fatalErrIrq)
    else $error("noncorrectable error not raised");

endmodule

// File: bmmc_req_model.sv
// requester model: bus control of the cpu or dma side of the bus
// assumes one caller at a time, tasks started from the testbench
`timescale 1ns/10ps
module bmmc_req_model (
  // clock
  input  wire logic                    sys_clk,
  // requests to the module
  output bmmc_pkg::bmmc_bus_req_t      busReq,
  // answers from the module
  input  wire logic                    dataReadyAck,
  input  wire logic                    busDataOe,
  input  wire logic     [15:0]         busDataOut
);
  initial busReq = '0;

  // ***************************************************
  // bus cycles
  // ***************************************************
  // cycle, strobe and data present drop, address and data toggle, so a stale value never looks valid
  task automatic release_bus();
    busReq.memCycleActive    <= 1'b0;
    busReq.addrPresentStrobe <= 1'b0;
    busReq.dataPresent       <= 1'b0;
    busReq.addr              <= ~busReq.addr;
    busReq.wdata             <= ~busReq.wdata;
  endtask

  task automatic access(input logic wr, input logic [23:0] a,
                        input logic [15:0] d, input int dpDly,
                        output int lat, output logic [15:0] rd,
                        output logic oeAck, output logic oeEarly);
    int n;
    begin
      n = 0;
      lat = 0;
      oeAck = 1'b0;
      oeEarly = 1'b0;
      rd = 16'h0000;
      @(posedge sys_clk);
      busReq.memCycleActive    <= 1'b1;
      busReq.writeDirection    <= wr;
      busReq.addrPresentStrobe <= 1'b1;
      busReq.addr              <= a;
      busReq.wdata             <= wr ? d : ~d;
      busReq.dataPresent       <= (dpDly == 0);
      while (lat == 0 && n < 12) begin
        @(negedge sys_clk);
        n++;
        if (dataReadyAck === 1'b1) begin
          lat = n;
          oeAck = busDataOe;
          rd = busDataOut;
        end else if (busDataOe !== 1'b0) begin
          oeEarly = 1'b1;
        end
        if (lat == 0) begin
          @(posedge sys_clk);
          // grant or data valid from the chosen cycle
          busReq.dataPresent <= (n >= dpDly);
        end
      end
      @(posedge sys_clk);
      release_bus();
    end
  endtask

  task automatic refresh(output int lat);
    int n;
    begin
      n = 0;
      lat = 0;
      @(posedge sys_clk);
      // refresh broadcast with no other owner
      busReq.refreshCmd <= 1'b1;
      while (lat == 0 && n < 12) begin
        @(negedge sys_clk);
        n++;
        if (dataReadyAck === 1'b1) lat = n;
      end
      @(posedge sys_clk);
      busReq.refreshCmd <= 1'b0;
    end
  endtask
endmodule

// File: testbench.sv
// self-checking bench for the memory module controller
// assumes the requester model and a behavioural 22-bit array here
`timescale 1ns/10ps
module testbench;
  logic                    sys_clk;
  logic                    rst_n;
  bmmc_pkg::bmmc_bus_req_t busReq;
  bmmc_pkg::bmmc_arr_cmd_t arrCmd;
  logic                    dataReadyAck, busDataOe;
  logic [15:0]             busDataOut;
  logic [21:0]             arrRdata, errMask;
  logic [7:0]              lowerLimitSwitch;
  logic [3:0]              slotPositionCode, blockLamp;
  logic [9:0]              nextLowerLimit, lower;
  logic                    limitIllegal, singleErrReport, fatalErrIrq;
  logic [21:0]             mem [logic [15:0]];
  logic [23:0]             expAddr;
  logic [15:0]             expData;
  logic [6:0]              refRow;
  logic [31:0]             seed;
  int                      miscompares, checks_done, nSingle, nFatal;
  wire  [15:0] arrKey = {arrCmd.blockSel, arrCmd.colAddr, arrCmd.rowAddr};

  bmmc_ctrl bmmc_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .busReq(busReq), .dataReadyAck(dataReadyAck), .busDataOe(busDataOe),
    .busDataOut(busDataOut), .arrCmd(arrCmd), .arrRdata(arrRdata),
    .lowerLimitSwitch(lowerLimitSwitch),
    .slotPositionCode(slotPositionCode), .nextLowerLimit(nextLowerLimit),
    .blockLamp(blockLamp), .limitIllegal(limitIllegal),
    .singleErrReport(singleErrReport), .fatalErrIrq(fatalErrIrq));
  bmmc_req_model bmmc_req_model_inst (.sys_clk(sys_clk), .busReq(busReq),
    .dataReadyAck(dataReadyAck), .busDataOe(busDataOe),
    .busDataOut(busDataOut));

  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reset_dut(input logic [7:0] sw, input logic [3:0] slot);
    @(posedge sys_clk);
    lowerLimitSwitch <= sw;
    slotPositionCode <= slot;
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask

  // write, then read back with an optional stored fault
  task automatic rw(input logic [23:0] a, input logic [15:0] d,
                    input int kind);
    int lat, dly, base, p, q;
    logic [15:0] rd;
    logic oeAck, oeEarly;
    begin
      p = rnd() % 22;
      q = (p + 1 + rnd() % 21) % 22;
      expAddr = a;
      expData = d;
      errMask = kind == 0 ? 22'h0 : 22'h1 << p;
      if (kind == 2) errMask = errMask | 22'h1 << q;
      dly = 1 + rnd() % 3;
      bmmc_req_model_inst.access(1'b1, a, d, dly, lat, rd, oeAck, oeEarly);
      chk(32'(lat), 32'(dly + 2));
      chk(32'({oeAck, oeEarly}), 32'h0);
      chk(32'(blockLamp), 32'(4'h1 << a[15:14]));
      nSingle = 0;
      nFatal = 0;
      dly = rnd() % 6;
      base = kind == 1 ? 5 : 4;
      bmmc_req_model_inst.access(1'b0, a, d, dly, lat, rd, oeAck, oeEarly);
      // fault mask kept until the write has surely landed
      errMask = 22'h0;
      chk(32'({oeAck, oeEarly}), 32'h2);
      chk(32'(lat), 32'(dly + 1 > base ? dly + 1 : base));
      if (kind != 2) chk(32'(rd), 32'(d));
      chk(32'(nSingle * 16 + nFatal), kind == 0 ? 32'h0 :
          kind == 1 ? 32'h10 : 32'h1);
    end
  endtask

  // ***************************************************
  // array model and monitors
  // ***************************************************
  always @(posedge sys_clk) begin
    if (arrCmd.writeEn === 1'b1) mem[arrKey] = arrCmd.wdata ^ errMask;
    if (arrCmd.readEn === 1'b1 && mem.exists(arrKey))
      arrRdata <= mem[arrKey];
    else
      arrRdata <= ~arrRdata;
  end

  always @(negedge sys_clk) begin
    if (arrCmd.readEn === 1'b1 || arrCmd.writeEn === 1'b1)
      chk(32'(arrKey), 32'(expAddr[15:0]));
    if (arrCmd.writeEn === 1'b1) begin
      chk(32'(arrCmd.wdata[15:0]), 32'(expData));
      chk(32'(^arrCmd.wdata), 32'h0);
    end
    if (arrCmd.refreshEn === 1'b1) refRow = arrCmd.rowAddr;
    if (singleErrReport === 1'b1) nSingle++;
    if (fatalErrIrq === 1'b1) nFatal++;
  end

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // limit: placement, data and refresh runs with margin
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end

  // ***************************************************
  // tests
  // ***************************************************
  initial begin : main
    int i, lat;
    logic [7:0] sw;
    logic legal, oeA, oeE;
    logic [15:0] rd;
    seed = 32'h0fa211b8;
    rst_n = 1'b0;
    arrRdata = 22'h0;
    errMask = 22'h0;
    lowerLimitSwitch = 8'h00;
    slotPositionCode = 4'h0;
    for (i = 0; i < 11; i++) begin
      sw = i < 10 ? 8'(i) : 8'h88;
      reset_dut(sw, 4'(rnd()));
      lower = sw == 8'h88 ? 10'(slotPositionCode) * 10'h004 : 10'(sw);
      legal = sw <= 8'h08 || sw == 8'h88;
      chk(32'(limitIllegal), 32'(!legal));
      if (legal) begin
        chk(32'(nextLowerLimit), 32'(lower + 10'h004));
        rw({lower + 10'(rnd() % 4), 14'(rnd())}, 16'(rnd()), 0);
        lower = rnd() % 2 ? lower + 10'h004 : lower - 10'h001;
      end
      bmmc_req_model_inst.access(1'b0, {lower, 14'(rnd())}, 16'h0, 0,
                                 lat, rd, oeA, oeE);
      chk(32'(lat), 32'h0);
      chk(32'({oeA, oeE}), 32'h0);
    end
    $display("test placement done");
    lower = 10'(slotPositionCode) * 10'h004;
    // block edges first, then random traffic
    for (i = 0; i < 44; i++) begin
      if (i < 4)
        rw({lower + 10'(i), i[0] ? 14'h3fff : 14'h0000},
           i[1] ? 16'hffff : 16'h0000, i % 3);
      else
        rw({lower + 10'(rnd() % 4), 14'(rnd())}, 16'(rnd()),
           rnd() % 3);
    end
    $display("test data done");
    for (i = 0; i < 130; i++) begin
      bmmc_req_model_inst.refresh(lat);
      chk(32'(lat), 32'h3);
      chk(32'(refRow), 32'(i % 128));
      repeat (126) @(posedge sys_clk);
    end
    $display("test refresh done");
    finish_test();
  end
endmodule
